// ===== cbx_pkg.sv
// Purpose: shared constants and carriers for the branch and and-immediate
//          execute block
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes:   opcode and selector encodings plus result carriers
`default_nettype none
package cbx_pkg;
    // primary opcodes
    localparam logic [5:0] OP_AND_ZERO_EXT_CONSTANT = 6'h0C;
    localparam logic [5:0] OP_BRANCH_IF_EQUAL = 6'h04;
    localparam logic [5:0] OP_BRANCH_IF_EQUAL_NULLIFYING = 6'h14;
    localparam logic [5:0] OP_REGISTER_CONSTANT_CLASS = 6'h01;
    // selector codes in the second register field
    localparam logic [4:0] SEL_BRANCH_IF_NONNEGATIVE = 5'h01;
    localparam logic [4:0] SEL_BRANCH_IF_NONNEGATIVE_NULLIFYING = 5'h03;
    localparam logic [4:0] SEL_CALL_IF_NONNEGATIVE = 5'h11;
    localparam logic [4:0] SEL_CALL_IF_NONNEGATIVE_NULLIFYING = 5'h13;
    // field positions
    localparam int OPCODE_MSB = 31;
    localparam int OPCODE_LSB = 26;
    localparam int FIRST_SRC_MSB = 25;
    localparam int FIRST_SRC_LSB = 21;
    localparam int SECOND_REG_MSB = 20;
    localparam int SECOND_REG_LSB = 16;
    localparam int CONST_MSB = 15;
    localparam int SIGN_BIT = 63;
    // fixed values
    localparam logic [4:0] LINK_REG = 5'h1F;
    localparam logic [63:0] LINK_STEP = 64'h0000_0000_0000_0008;
    localparam logic [63:0] SLOT_STEP = 64'h0000_0000_0000_0004;
    localparam logic [63:0] RESET_PC = 64'h0000_0000_0000_0000;
    localparam logic [4:0] RESET_REG = 5'h00;

    // instruction arriving from decode
    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [63:0] pc;
        logic [63:0] first_value;
        logic [63:0] second_value;
        logic in_slot;
    } cbx_issue_t;

    // register file write
    typedef struct packed {
        logic en;
        logic [4:0] idx;
        logic [63:0] data;
    } cbx_write_t;

    // program counter redirect toward fetch
    typedef struct packed {
        logic valid;
        logic [63:0] target;
    } cbx_redirect_t;
endpackage
`default_nettype wire

// ===== cbx_exec.sv
// Purpose: execute and-immediate and conditional pc-relative branches
// Assumes: operands read by decode; in_slot marks the delay-slot word
// Notes:   all outputs registered; one instruction accepted per clock
`timescale 1ns/10ps
`default_nettype none
module cbx_exec
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire cbx_pkg::cbx_issue_t issue_in,
    output cbx_pkg::cbx_write_t write_out,
    output cbx_pkg::cbx_redirect_t redirect_out,
    output logic cancel_delay_slot_out,
    output logic [63:0] restart_pc_out,
    output logic restart_in_slot_out,
    output logic not_handled_out,
    output logic arith_exception_out
);
    import cbx_pkg::*;

    // how the block is organised:
    // - decode is purely combinational on the arriving word
    // - every output is a flip-flop, so answers trail the taking edge
    //   by exactly one clock
    // - a branch does not redirect or cancel when it issues; its decision, target and
    //   nullify flavour are frozen in the pending set of registers
    // - the next valid word with in_slot high is the delay-slot word,
    //   and it is at that word that redirect or cancel is produced
    // - any number of idle cycles may separate a branch from its slot;
    //   the pending state simply waits for the slot word
    // - a branch word presented with in_slot high is never treated as
    //   a branch; nested branches in a slot are left to the core
    // - the link write of a call happens at the branch word itself,
    //   whatever the condition, so a re-executed call relinks the same
    //   value as long as its source is not the link register
    // - the sign tests read only bit 63, so no subtraction or
    //   comparator is needed for the non-negative family
    // - the equal compare is a full 64-bit match; a difference in any
    //   single bit, the sign bit included, makes it untaken
    // - the and-immediate path has no carry chain at all, so it can
    //   never raise an arithmetic fault
    // - selectors of the class opcode that are not decoded here are
    //   flagged one cycle later and produce no other effect
    // limitations:
    // - one word per clock at most, no stall input; the core must hold
    //   off issue itself if it cannot take an answer
    // - the restart point tracks the most recent valid word only
    // - a second branch before the slot of the first overwrites the
    //   pending state; the core never issues such a sequence

    // branch decisions held until the delay slot passes
    logic pending;
    logic pending_taken;
    logic pending_nullify;
    logic [63:0] pending_target;
    logic [63:0] branch_pc;

    // decoded fields of the arriving word
    logic [5:0] opcode;
    logic [4:0] second_field;
    logic [15:0] offset;
    logic is_and;
    logic is_eq;
    logic is_eq_null;
    logic is_class;
    logic sel_known;
    logic sel_null;
    logic sel_call;
    logic is_branch;
    logic cond;
    logic [63:0] slot_pc;
    logic [63:0] next_target;

    // offset shifted two places, sign-extended from 18 bits
    function automatic logic [63:0] branch_disp(input logic [15:0] off);
        branch_disp = {{46{off[15]}}, off, 2'b00};
    endfunction

    // full-width equality for the compare branches
    function automatic logic regs_equal(input logic [63:0] a,
                                        input logic [63:0] b);
        regs_equal = (a == b);
    endfunction

    // field extraction and classification
    always_comb
    begin
        opcode = issue_in.word[OPCODE_MSB:OPCODE_LSB];
        second_field = issue_in.word[SECOND_REG_MSB:SECOND_REG_LSB];
        offset = issue_in.word[CONST_MSB:0];
        is_and = opcode == OP_AND_ZERO_EXT_CONSTANT;
        is_eq = opcode == OP_BRANCH_IF_EQUAL;
        is_eq_null = opcode == OP_BRANCH_IF_EQUAL_NULLIFYING;
        is_class = opcode == OP_REGISTER_CONSTANT_CLASS;
        // selector picks the variant under the class opcode
        sel_known = (second_field == SEL_BRANCH_IF_NONNEGATIVE)
            || (second_field == SEL_BRANCH_IF_NONNEGATIVE_NULLIFYING)
            || (second_field == SEL_CALL_IF_NONNEGATIVE)
            || (second_field == SEL_CALL_IF_NONNEGATIVE_NULLIFYING);
        sel_null = (second_field == SEL_BRANCH_IF_NONNEGATIVE_NULLIFYING)
            || (second_field == SEL_CALL_IF_NONNEGATIVE_NULLIFYING);
        sel_call = (second_field == SEL_CALL_IF_NONNEGATIVE)
            || (second_field == SEL_CALL_IF_NONNEGATIVE_NULLIFYING);
        is_branch = is_eq || is_eq_null || (is_class && sel_known);
        // condition per family
        if (is_class)
        begin
            cond = ~issue_in.first_value[SIGN_BIT];
        end
        else
        begin
            cond = regs_equal(issue_in.first_value, issue_in.second_value);
        end
        // target relative to the delay-slot address
        slot_pc = issue_in.pc + SLOT_STEP;
        next_target = slot_pc + branch_disp(offset);
    end

    // a word counts only if it is valid and not cancelled
    logic live;
    assign live = issue_in.valid && !(issue_in.in_slot && pending
        && pending_nullify && !pending_taken);

    // branch bookkeeping across the delay slot
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            pending <= 1'b0;
            pending_taken <= 1'b0;
            pending_nullify <= 1'b0;
            pending_target <= RESET_PC;
            branch_pc <= RESET_PC;
        end
        else if (live && is_branch && !issue_in.in_slot)
        begin
            // decision frozen at the branch, acted on at the slot
            pending <= 1'b1;
            pending_taken <= cond;
            pending_nullify <= is_eq_null || (is_class && sel_null);
            pending_target <= next_target;
            branch_pc <= issue_in.pc;
        end
        else if (issue_in.valid && issue_in.in_slot)
        begin
            // slot has gone by, cancelled or not
            pending <= 1'b0;
        end
    end

    // redirect timing:
    // - the redirect pulse is raised in the clock after the slot word
    //   is taken, so fetch never sees a valid redirect before the slot word
    //   has been accepted
    // - the target is copied every clock; only valid qualifies it, and
    //   fetch must ignore the target while valid is low
    // - a nullified slot of an untaken branch gives no redirect, and
    //   fetch then simply carries on at the fall-through address
    // redirect only once the slot itself has issued
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            redirect_out <= '0;
        end
        else
        begin
            redirect_out.valid <= issue_in.valid && issue_in.in_slot
                && pending && pending_taken;
            redirect_out.target <= pending_target;
        end
    end

    // slot cancel: untaken nullifying branch kills the slot
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            cancel_delay_slot_out <= 1'b0;
        end
        else
        begin
            cancel_delay_slot_out <= issue_in.valid && issue_in.in_slot
                && pending && pending_nullify && !pending_taken;
        end
    end

    // register write port sharing:
    // - the and-immediate result and the call link share one write
    //   port; a single word can never need both, so no arbitration
    // - a cancelled slot word is filtered by live and writes nothing
    // - the link is pc plus eight on the full 64-bit pc, which is
    //   already zero-extended, so no extra widening is required
    // - when nothing is written the index and data are cleared, so a
    //   stale value never sits on the port beside a low enable
    // - a call word in a delay slot is not a branch and writes no link
    // register results: and-immediate and the link
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            write_out <= '0;
        end
        else if (live && is_and)
        begin
            write_out.en <= 1'b1;
            write_out.idx <= second_field;
            // upper 48 bits are zero by construction
            write_out.data <= {48'h0, offset}
                & issue_in.first_value;
        end
        else if (live && is_class && sel_call && !issue_in.in_slot)
        begin
            // link written whatever the condition says
            write_out.en <= 1'b1;
            write_out.idx <= LINK_REG;
            write_out.data <= issue_in.pc + LINK_STEP;
        end
        else
        begin
            write_out.en <= 1'b0;
            write_out.idx <= RESET_REG;
            write_out.data <= '0;
        end
    end

    // restart tracking:
    // - a fault in a delay slot must resume at the branch, so that the
    //   condition and the link are worked out again on restart
    // - re-execution gives the same outcome only while the call does
    //   not name the link register as its source; software keeps to
    //   that and this logic does not check it
    // - outside a slot the restart point is the word itself
    // - both outputs hold their value across idle cycles
    // restart point: a slot fault resumes at the branch
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            restart_pc_out <= RESET_PC;
            restart_in_slot_out <= 1'b0;
        end
        else if (issue_in.valid)
        begin
            // relies on the link source never being register 31
            if (issue_in.in_slot && pending)
            begin
                restart_pc_out <= branch_pc;
                restart_in_slot_out <= 1'b1;
            end
            else
            begin
                restart_pc_out <= issue_in.pc;
                restart_in_slot_out <= 1'b0;
            end
        end
    end

    // hand-off of what this block does not decode:
    // - the flag is a one-cycle pulse beside the absent write
    // - other decode logic or the exception unit takes it from there
    // - the arithmetic fault output is tied low in a register so that
    //   it still comes straight from a flip-flop like every output
    // unknown class selectors go to other decode logic
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            not_handled_out <= 1'b0;
            arith_exception_out <= 1'b0;
        end
        else
        begin
            not_handled_out <= live && is_class && !sel_known;
            arith_exception_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== cbx_exec_chk.sv
// Purpose: port-level assertions for the branch and and-immediate block
// Assumes: answers appear one cycle after the taking edge
// Notes: bound to cbx_exec at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module cbx_exec_chk
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire cbx_pkg::cbx_issue_t issue_in,
    input wire cbx_pkg::cbx_write_t write_out,
    input wire cbx_pkg::cbx_redirect_t redirect_out,
    input wire logic cancel_delay_slot_out,
    input wire logic [63:0] restart_pc_out,
    input wire logic restart_in_slot_out,
    input wire logic not_handled_out,
    input wire logic arith_exception_out
);
    import cbx_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // decoded view of the word being taken
    logic [5:0] op;
    logic [4:0] sel;
    logic head;
    logic slot;
    logic cls;
    assign op = issue_in.word[31:26];
    assign sel = issue_in.word[20:16];
    assign head = issue_in.valid && !issue_in.in_slot;
    assign slot = issue_in.valid && issue_in.in_slot;
    assign cls = head && op == OP_REGISTER_CONSTANT_CLASS;
    // call word taken, then its link write
    sequence s_call;
        cls && (sel == SEL_CALL_IF_NONNEGATIVE ||
            sel == SEL_CALL_IF_NONNEGATIVE_NULLIFYING);
    endsequence
    sequence s_link;
        write_out.en && write_out.idx == LINK_REG &&
            write_out.data == $past(issue_in.pc) + LINK_STEP;
    endsequence
    property p_and_write;
        head && op == OP_AND_ZERO_EXT_CONSTANT |=> write_out.en &&
            write_out.data == ({48'h0, $past(issue_in.word[15:0])} &
            $past(issue_in.first_value));
    endproperty
    a_and_write: assert property (p_and_write)
        else $error("and-immediate write wrong");
    property p_link;
        s_call |=> s_link;
    endproperty
    a_link: assert property (p_link)
        else $error("link write missing");
    property p_no_arith;
        arith_exception_out == 1'b0;
    endproperty
    a_no_arith: assert property (p_no_arith)
        else $error("arithmetic exception raised");
    property p_not_handled;
        cls && sel != SEL_BRANCH_IF_NONNEGATIVE && !sel[4] && !sel[1]
            |=> not_handled_out && !write_out.en;
    endproperty
    a_not_handled: assert property (p_not_handled)
        else $error("unknown selector not flagged");
    property p_redirect_after_slot;
        redirect_out.valid |-> $past(slot);
    endproperty
    a_redirect_after_slot: assert property (p_redirect_after_slot)
        else $error("redirect before slot word");
    property p_cancel_after_slot;
        $rose(cancel_delay_slot_out) |-> $past(slot);
    endproperty
    a_cancel_after_slot: assert property (p_cancel_after_slot)
        else $error("cancel without slot word");
    property p_cancel_excl;
        cancel_delay_slot_out |-> !redirect_out.valid && !write_out.en;
    endproperty
    a_cancel_excl: assert property (p_cancel_excl)
        else $error("cancelled slot had an effect");
    property p_slot_restart;
        slot ##1 1'b1 |-> restart_in_slot_out;
    endproperty
    a_slot_restart: assert property (p_slot_restart)
        else $error("slot restart flag missing");
endmodule
bind cbx_exec cbx_exec_chk u_chk (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .issue_in(issue_in), .write_out(write_out),
    .redirect_out(redirect_out), .restart_pc_out(restart_pc_out),
    .cancel_delay_slot_out(cancel_delay_slot_out),
    .restart_in_slot_out(restart_in_slot_out),
    .not_handled_out(not_handled_out),
    .arith_exception_out(arith_exception_out));
`default_nettype wire

// ===== cond_branch_and_logic_imm_exec_tb_top.sv
// Purpose: random and corner stimulus for the branch and and-immediate block
// Assumes: one word per two cycles, slot word follows its branch
// Notes: expectations come from the bench functions below
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
 $display("CHECK FAILED at %0t: value mismatch", $time); end end
module cond_branch_and_logic_imm_exec_tb_top;
    import cbx_pkg::*;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    cbx_issue_t issue_in = '0;
    cbx_write_t write_out;
    cbx_redirect_t redirect_out;
    logic cancel_delay_slot_out, restart_in_slot_out;
    logic not_handled_out, arith_exception_out;
    logic [63:0] restart_pc_out, a;
    int num_errors = 0, num_checks = 0, seed = 72811;
    logic [5:0] ops [6] = '{OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_EQUAL_NULLIFYING,
        6'h01, 6'h01, 6'h01, 6'h01};
    logic [4:0] sels [6] = '{5'h00, 5'h00, SEL_BRANCH_IF_NONNEGATIVE,
        SEL_BRANCH_IF_NONNEGATIVE_NULLIFYING, SEL_CALL_IF_NONNEGATIVE,
        SEL_CALL_IF_NONNEGATIVE_NULLIFYING};
    logic [4:0] bad [5] = '{5'h00, 5'h02, 5'h10, 5'h12, 5'h1F};
    // free-running 200 MHz clock
    always #2.5 clk_sys_in = ~clk_sys_in;
    cbx_exec uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .issue_in(issue_in), .write_out(write_out),
        .redirect_out(redirect_out), .restart_pc_out(restart_pc_out),
        .cancel_delay_slot_out(cancel_delay_slot_out),
        .restart_in_slot_out(restart_in_slot_out),
        .not_handled_out(not_handled_out),
        .arith_exception_out(arith_exception_out));
    // taken target: slot address plus shifted, sign-extended offset
    function automatic logic [63:0] tgt(logic [63:0] p, logic [15:0] o);
        return p + SLOT_STEP + {{46{o[15]}}, o, 2'b00};
    endfunction
    // one word held for one taking edge; answer settled after #1
    task automatic send(input logic [31:0] w, input logic [63:0] pc, x, y,
        input logic s);
        @(posedge clk_sys_in);
        issue_in <= '{1'b1, w, pc, x, y, s};
        @(posedge clk_sys_in);
        issue_in.valid <= 1'b0;
        #1;
    endtask
    // branch word then an and-immediate slot word
    task automatic branch_case(input int k, input logic [63:0] x, y,
        input logic [15:0] o);
        logic [63:0] p;
        logic [15:0] imm;
        logic cl, nul, tk;
        p = {$random(seed), $random(seed)} & ~64'h3;
        imm = $random(seed);
        cl = sels[k][4];
        // both nullifying selectors carry bit 1
        nul = k == 1 || (k > 1 && sels[k][1]);
        tk = (k < 2) ? x == y : !x[63];
        // source field is 5, never the link register
        send({ops[k], 5'h05, k < 2 ? 5'h06 : sels[k], o}, p, x, y, 1'b0);
        `CHK(write_out.en, cl)
        if (cl) `CHK(write_out.data, p + LINK_STEP)
        if (cl) `CHK(write_out.idx, LINK_REG)
        `CHK(redirect_out.valid, 1'b0)
        send({OP_AND_ZERO_EXT_CONSTANT, 5'h02, 5'h09, imm}, p + SLOT_STEP,
            x, y, 1'b1);
        `CHK(redirect_out.valid, tk)
        if (tk) `CHK(redirect_out.target, tgt(p, o))
        `CHK(cancel_delay_slot_out, nul && !tk)
        `CHK(write_out.en, !(nul && !tk))
        if (!nul || tk) `CHK(write_out.data, {48'h0, imm} & x)
        `CHK(restart_pc_out, p)
        `CHK(restart_in_slot_out, 1'b1)
    endtask
    // prints the counts and the verdict, then stops
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        `CHK(write_out.en, 1'b0)
        reset_n_in <= 1'b1;
        // and-immediate with random operands
        for (int j = 0; j < 20; j++)
        begin
            logic [15:0] imm;
            logic [4:0] rt;
            a = {$random(seed), $random(seed)};
            imm = (j == 0) ? 16'hFFFF : $random(seed);
            rt = $random(seed);
            send({OP_AND_ZERO_EXT_CONSTANT, 5'h03, rt, imm}, 64'h100, a, a,
                1'b0);
            `CHK(write_out.en, 1'b1)
            `CHK(write_out.idx, rt)
            `CHK(write_out.data, {48'h0, imm & a[15:0]})
            `CHK(arith_exception_out, 1'b0)
        end
        $display("test and-immediate done");
        // every branch kind: equal, differ in bit 63 only, random
        for (int k = 0; k < 6; k++)
            for (int j = 0; j < 12; j++)
            begin
                a = {$random(seed), $random(seed)};
                if (j == 3)
                    a = 64'h0;
                if (j == 4)
                    a = 64'h8000_0000_0000_0000;
                branch_case(k, a, (j % 3 == 0) ? a : (j % 3 == 1) ?
                    a ^ 64'h8000_0000_0000_0000 : {$random(seed),
                    $random(seed)}, (j == 1) ? 16'h8000 : (j == 2) ?
                    16'h7FFF : $random(seed));
            end
        $display("test branches done");
        // selectors this block leaves to others
        foreach (bad[i])
        begin
            send({OP_REGISTER_CONSTANT_CLASS, 5'h04, bad[i], 16'h0010},
                64'h200, 64'h0, 64'h0, 1'b0);
            `CHK(not_handled_out, 1'b1)
            `CHK(redirect_out.valid | write_out.en, 1'b0)
        end
        $display("test unknown selectors done");
        wrap_up();
    end
endmodule
`default_nettype wire
